// *** core/count_if.sv ***
`timescale 1ns/100ps
interface count_if;
  logic                        step;
  logic                        up;
  logic                        run;
  logic                        clear;
  quad_counter_pkg::count_t    value;

  modport ctrl (output step, output up, output run, output clear, input value);
  modport cnt  (input step, input up, input run, input clear, output value);
endinterface

// *** core/quad_counter_pkg.sv ***
package quad_counter_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

  typedef logic [31:0] count_t;

endpackage

// *** core/quad_counter_regs.svh ***
`ifndef QUAD_COUNTER_REGS_SVH
`define QUAD_COUNTER_REGS_SVH

// Word offsets (byte addresses) of the register map
`define QC_LATCH_OFS    8'h00
`define QC_ENABLE_OFS   8'h04
`define QC_CLEAR_OFS    8'h08
`define QC_LATCHCMD_OFS 8'h0C
`define QC_INPUTS_OFS   8'h10
`define QC_LIVE_OFS     8'h14

// Field positions
`define QC_CMD_BIT      0
`define QC_PHASE_A_BIT  0
`define QC_PHASE_B_BIT  1

// Reset values
`define QC_COUNT_RST    32'h0000_0000
`define QC_ENABLE_RST   1'b0

`endif

// *** core/quadrature_updown_counter.sv ***
`timescale 1ns/100ps
`include "quad_counter_regs.svh"
// Behaviour
// - Single 32-bit up/down counter register
// - Count only on decoded encoder edges
// - Software reads count only via latch
// - Control registers for enable, clear, latch
// - Two quadrature inputs give step, direction
// - Step on every edge of one input alone; a change of both at once gives none
// - Direction from edge order of phases
// - Phase levels readable as digital inputs
// - Enable bit runs or stops, persists
// - Latch bit copies count; zero ignored
// - Clear and latch bits self-reset
module quadrature_updown_counter (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // Encoder phases
  input  wire logic        phase_a_in,
  input  wire logic        phase_b_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out
);

  count_if cnt_bus ();

  // Phase synchronisers and edge history
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      prev_reg  <= 2'h0;
    end else begin
      sync1_reg <= {phase_b_in, phase_a_in};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Four-edge decode: any single-phase change is one step
  logic       a_edge;
  logic       b_edge;
  logic       step;
  logic       dir_up;

  assign a_edge = sync2_reg[0] ^ prev_reg[0];
  assign b_edge = sync2_reg[1] ^ prev_reg[1];
  assign step   = a_edge ^ b_edge;
  // A leading B counts up: on an A change, new A differs from B
  assign dir_up = a_edge ? (sync2_reg[0] != sync2_reg[1])
                         : (sync2_reg[0] == sync2_reg[1]);

  assign cnt_bus.step = step;
  assign cnt_bus.up   = dir_up;

  updown_counter #(
    .WIDTH (32)
  ) counter_u (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .bus      (cnt_bus.cnt)
  );

  // Wishbone access decode
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  quad_counter_pkg::bus_state_t state_reg;
  logic                         wr_take;
  logic                         rd_take;
  logic                         cmd_one;

  assign wr_take = wb_cyc_in && wb_stb_in && wb_we_in && state_reg == quad_counter_pkg::BUS_IDLE;
  assign rd_take = wb_cyc_in && wb_stb_in && !wb_we_in
                   && state_reg == quad_counter_pkg::BUS_IDLE;
  assign cmd_one = wb_sel_in[0] && wb_dat_in[`QC_CMD_BIT];

  // Ack follows the taking edge by one cycle; a held request waits one idle cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= quad_counter_pkg::BUS_IDLE;
    end else begin
      case (state_reg)
        quad_counter_pkg::BUS_IDLE: begin
          if (wb_cyc_in && wb_stb_in) begin
            state_reg <= quad_counter_pkg::BUS_ACK;
          end
        end
        quad_counter_pkg::BUS_ACK: begin
          state_reg <= quad_counter_pkg::BUS_IDLE;
        end
        default: begin
          state_reg <= quad_counter_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_out = (state_reg == quad_counter_pkg::BUS_ACK);

  // Enable bit persists until the opposite value is written
  logic enable_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_reg <= `QC_ENABLE_RST;
    end else if (wr_take && hit(wb_adr_in, `QC_ENABLE_OFS) && wb_sel_in[0]) begin
      enable_reg <= wb_dat_in[`QC_CMD_BIT];
    end
  end

  assign cnt_bus.run = enable_reg;

  // Clear and latch commands: one-cycle pulses, auto-returning to zero
  logic clear_reg;
  logic latch_cmd_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clear_reg     <= 1'b0;
      latch_cmd_reg <= 1'b0;
    end else begin
      clear_reg     <= wr_take && hit(wb_adr_in, `QC_CLEAR_OFS) && cmd_one;
      latch_cmd_reg <= wr_take && hit(wb_adr_in, `QC_LATCHCMD_OFS) && cmd_one;
    end
  end

  assign cnt_bus.clear = clear_reg;

  // Holding latch, the only path from the counter to software
  quad_counter_pkg::count_t latch_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_reg <= `QC_COUNT_RST;
    end else if (latch_cmd_reg) begin
      latch_reg <= cnt_bus.value;
    end
  end

  // Read data register
  logic [31:0] rd_next;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit(wb_adr_in, `QC_LATCH_OFS)) begin
      rd_next = latch_reg;
    end else if (hit(wb_adr_in, `QC_ENABLE_OFS)) begin
      rd_next[`QC_CMD_BIT] = enable_reg;
    end else if (hit(wb_adr_in, `QC_CLEAR_OFS)) begin
      rd_next[`QC_CMD_BIT] = clear_reg;
    end else if (hit(wb_adr_in, `QC_LATCHCMD_OFS)) begin
      rd_next[`QC_CMD_BIT] = latch_cmd_reg;
    end else if (hit(wb_adr_in, `QC_INPUTS_OFS)) begin
      rd_next[`QC_PHASE_A_BIT] = sync2_reg[0];
      rd_next[`QC_PHASE_B_BIT] = sync2_reg[1];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (rd_take) begin
      wb_dat_out <= rd_next;
    end
  end

  // Checks
  sequence clear_write_s;
    wr_take && hit(wb_adr_in, `QC_CLEAR_OFS) && cmd_one;
  endsequence

  sequence latch_write_s;
    wr_take && hit(wb_adr_in, `QC_LATCHCMD_OFS) && cmd_one;
  endsequence

  sequence enable_write_s;
    wr_take && hit(wb_adr_in, `QC_ENABLE_OFS) && wb_sel_in[0];
  endsequence

  sequence latch_read_s;
    rd_take && hit(wb_adr_in, `QC_LATCH_OFS);
  endsequence

  sequence inputs_read_s;
    rd_take && hit(wb_adr_in, `QC_INPUTS_OFS);
  endsequence

  sequence quiet_read_s;
    rd_take && (hit(wb_adr_in, `QC_CLEAR_OFS) || hit(wb_adr_in, `QC_LATCHCMD_OFS));
  endsequence

  sequence live_read_s;
    rd_take && hit(wb_adr_in, `QC_LIVE_OFS);
  endsequence

  // Decoder
  one_step_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $onehot({phase_b_in, phase_a_in} ^ $past({phase_b_in, phase_a_in})) |-> ##2 step)
    else $error("Phase edge gave no step");

  both_change_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (a_edge && b_edge) |-> !step)
    else $error("Double phase change gave a step");

  no_edge_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (sync2_reg == prev_reg) |-> !step)
    else $error("Step without a phase edge");

  up_order_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (prev_reg == 2'h0 && sync2_reg == 2'h1) |-> dir_up)
    else $error("A rising before B did not count up");

  down_order_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (prev_reg == 2'h0 && sync2_reg == 2'h2) |-> !dir_up)
    else $error("B rising before A did not count down");

  sync_delay_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    1'b1 |-> ##2 sync2_reg == $past({phase_b_in, phase_a_in}, 2))
    else $error("Phase synchroniser delay is not two cycles");

  // Bus handshake
  ack_once_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("Ack held longer than one cycle");

  ack_after_req_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
    else $error("Request was not acknowledged in the next cycle");

  no_ack_idle_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!(wb_cyc_in && wb_stb_in) && !wb_ack_out) |=> !wb_ack_out)
    else $error("Ack without a request");

  // Register effects
  clear_pulse_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    clear_write_s |=> clear_reg ##1 (!clear_reg && cnt_bus.value == 32'h0000_0000))
    else $error("Clear did not zero the counter and self-reset");

  latch_copy_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    latch_write_s |=> latch_cmd_reg ##1 (!latch_cmd_reg
      && latch_reg == $past(cnt_bus.value)))
    else $error("Latch did not capture the count");

  latch_stable_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !latch_cmd_reg |=> $stable(latch_reg))
    else $error("Latch changed without a latch command");

  enable_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !(wr_take && hit(wb_adr_in, `QC_ENABLE_OFS)) |=> $stable(enable_reg))
    else $error("Enable changed without a write");

  enable_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    enable_write_s |=> enable_reg == $past(wb_dat_in[`QC_CMD_BIT]))
    else $error("Enable did not take the written value");

  lane_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (wr_take && hit(wb_adr_in, `QC_ENABLE_OFS) && !wb_sel_in[0]) |=> $stable(enable_reg))
    else $error("Enable changed with its byte lane off");

  latch_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (wr_take && hit(wb_adr_in, `QC_LATCHCMD_OFS) && !cmd_one) |=> !latch_cmd_reg)
    else $error("Latch command fired on a zero write");

  clear_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (wr_take && hit(wb_adr_in, `QC_CLEAR_OFS) && !cmd_one) |=> !clear_reg)
    else $error("Clear fired on a zero write");

  cmd_once_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (clear_reg || latch_cmd_reg) |=> !(clear_reg || latch_cmd_reg))
    else $error("Command bit stayed set");

  // Read path
  latch_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    latch_read_s |=> wb_dat_out == $past(latch_reg))
    else $error("Latch read returned wrong data");

  inputs_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    inputs_read_s |=> wb_dat_out == {30'h0000_0000, $past(sync2_reg)})
    else $error("Input read returned wrong phase levels");

  quiet_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    quiet_read_s |=> wb_dat_out == 32'h0000_0000)
    else $error("Command bit read back as set");

  live_hidden_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    live_read_s |=> wb_dat_out == 32'h0000_0000)
    else $error("Reserved word did not read zero");

  dat_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !rd_take |=> $stable(wb_dat_out))
    else $error("Read data changed without a read");

endmodule

// *** core/updown_counter.sv ***
`timescale 1ns/100ps
`include "quad_counter_regs.svh"
module updown_counter #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Control and value
  count_if.cnt      bus
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (bus.clear) begin
      count_next = '0;
    end else if (bus.run && bus.step) begin
      // Wraps freely both ways; no overflow flag
      count_next = bus.up ? count_reg + 1'b1 : count_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= WIDTH'(`QC_COUNT_RST);
    end else begin
      count_reg <= count_next;
    end
  end

  assign bus.value = count_reg;

  step_moves_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!bus.clear && bus.run && bus.step) |=> count_reg != $past(count_reg))
    else $error("Enabled step did not move the counter");

  hold_still_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!bus.clear && !(bus.run && bus.step)) |=> count_reg == $past(count_reg))
    else $error("Counter moved without an enabled step");

  wrap_up_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!bus.clear && bus.run && bus.step && bus.up && count_reg == '1)
    |=> count_reg == '0)
    else $error("Counter did not wrap upward to zero");

endmodule

// *** test/encoder_model.sv ***
`timescale 1ns/100ps
module encoder_model (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Step request
  input  wire logic step_in,
  input  wire logic fwd_in,
  // Encoder phases
  output logic      phase_a_out,
  output logic      phase_b_out
);
  logic [1:0] pos_reg;
  // One phase edge per step, never both phases at once
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos_reg <= 2'h0;
    end else if (step_in) begin
      pos_reg <= fwd_in ? pos_reg + 2'h1 : pos_reg - 2'h1;
    end
  end
  // Forward: A rises while B is low
  assign phase_a_out = pos_reg[0] ^ pos_reg[1];
  assign phase_b_out = pos_reg[1];
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`include "quad_counter_regs.svh"
module tb_top;
  logic        mclk_in    = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        step       = 1'b0;
  logic        fwd        = 1'b1;
  logic        cyc        = 1'b0;
  logic        we         = 1'b0;
  logic [7:0]  adr        = 8'h00;
  logic [31:0] wdat       = 32'h0000_0000;
  logic [3:0]  sel        = 4'hF;
  logic        phase_a;
  logic        phase_b;
  logic [31:0] rdat;
  logic        ack;
  logic [31:0] q;
  int          num_errors = 0;
  int          n_compared = 0;

  always #12.5 mclk_in = ~mclk_in;

  encoder_model encoder_model_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .step_in(step),
    .fwd_in(fwd), .phase_a_out(phase_a), .phase_b_out(phase_b));
  quadrature_updown_counter quadrature_updown_counter_i (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .phase_a_in(phase_a), .phase_b_in(phase_b), .wb_cyc_in(cyc),
    .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack));

  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle, held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int t;
    t = 0;
    @(posedge mclk_in);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge mclk_in);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t >= 20) begin
      num_errors++;
      $display("[FAIL] %0t bus access got no ack", $time);
    end
    q = rdat;
    cyc <= 1'b0;
  endtask

  task automatic move(input int n, input logic f);
    repeat (n) begin
      @(posedge mclk_in);
      step <= 1'b1;
      fwd  <= f;
      @(posedge mclk_in);
      step <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
    repeat (6) @(posedge mclk_in);
  endtask

  task automatic latch_chk(input logic [31:0] exp);
    wb(1'b1, `QC_LATCHCMD_OFS, 32'h0000_0001);
    wb(1'b0, `QC_LATCH_OFS, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic t_reset();
    wb(1'b0, `QC_LATCH_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b0, `QC_ENABLE_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    move(4, 1'b1);
    latch_chk(32'h0000_0000);
  endtask

  task automatic t_count();
    wb(1'b1, `QC_ENABLE_OFS, 32'h0000_0001);
    move(6, 1'b1);
    latch_chk(32'h0000_0006);
    wb(1'b0, `QC_ENABLE_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    wb(1'b0, `QC_LIVE_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask

  task automatic t_latch_zero();
    move(2, 1'b1);
    wb(1'b1, `QC_LATCHCMD_OFS, 32'h0000_0000);
    wb(1'b0, `QC_LATCH_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0006);
    wb(1'b0, `QC_LATCHCMD_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b1, `QC_CLEAR_OFS, 32'h0000_0001, 4'hE);
    latch_chk(32'h0000_0008);
    wb(1'b0, `QC_LATCHCMD_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b1, `QC_ENABLE_OFS, 32'h0000_0000, 4'hE);
    wb(1'b0, `QC_ENABLE_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0001);
  endtask

  task automatic t_down();
    move(10, 1'b0);
    latch_chk(32'hFFFF_FFFE);
    wb(1'b0, `QC_INPUTS_OFS, 32'h0000_0000);
    chk(q, {30'h0, phase_b, phase_a});
  endtask

  task automatic t_clear();
    wb(1'b1, `QC_CLEAR_OFS, 32'h0000_0001);
    wb(1'b0, `QC_CLEAR_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    latch_chk(32'h0000_0000);
    move(1, 1'b0);
    latch_chk(32'hFFFF_FFFF);
    move(1, 1'b1);
    latch_chk(32'h0000_0000);
    wb(1'b1, `QC_ENABLE_OFS, 32'h0000_0000);
    move(3, 1'b1);
    latch_chk(32'h0000_0000);
    wb(1'b0, `QC_INPUTS_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0001);
  endtask

  initial begin
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_count();
    t_latch_zero();
    t_down();
    t_clear();
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    num_errors++;
    end_of_test();
  end
endmodule
